// ### tb/reg_host_model.sv
`timescale 1ns/10ps
module reg_host_model
(
  input wire logic clock,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWriteData
);
  initial
  begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWriteData = 8'h00;
  end
  // one strobe cycle, then bus left with flipped values
  task automatic acc(input logic wr, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge clock);
    #1;
    regWrite = wr;
    regRead = !wr;
    regAddr = a;
    regWriteData = d;
    @(posedge clock);
    #1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = ~a;
    regWriteData = ~d;
  endtask : acc
  // write, read back in the very next cycle, then release
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    regWrite = 1'b1;
    regRead = 1'b0;
    regAddr = a;
    regWriteData = d;
    @(posedge clock);
    #1;
    regWrite = 1'b0;
    regRead = 1'b1;
    @(posedge clock);
    #1;
    regRead = 1'b0;
    regAddr = ~a;
    regWriteData = ~d;
  endtask : wr_rd
endmodule : reg_host_model

// ### tb/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
  import haptic_cfg_pkg::*;
  typedef struct {int due; int kind; logic [11:0] v;} note_t;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic regWrite, regRead;
  logic [7:0] regAddr, regWriteData, regReadData;
  logic [7:0] inputLevel = 8'h00;
  logic resonantActuator = 1'b0;
  logic feedbackBrake = 1'b0;
  logic brakeNearDone = 1'b0;
  drive_cmd_s driveCmd;
  logic gainReduce;
  timing_ctrl_s timingFields;
  mode_sel_s modeFields;
  logic [SAMPLE_CNT_W-1:0] sampleCycles;
  logic [7:0] timingBits, modeBits;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  note_t q[$];
  note_t n;
  logic [31:0] seed = 32'hb9c0;
  logic [7:0] lv[6] = '{8'h00, 8'h40, 8'h7f, 8'h80, 8'hc0, 8'hff};
  logic [17:0] cfg[4] = '{{8'hda, 8'ha0, 2'h3}, {8'hda, 8'h80, 2'h2},
    {8'hda, 8'h81, 2'h3}, {8'h5a, 8'ha0, 2'h1}};
  reg_host_model host_i (.clock(clock), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData));
  haptic_loop_input_config haptic_loop_input_config_i (.clock(clock),
    .sys_rst(sys_rst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWriteData(regWriteData),
    .regReadData(regReadData), .inputLevel(inputLevel),
    .resonantActuator(resonantActuator), .feedbackBrake(feedbackBrake),
    .brakeNearDone(brakeNearDone), .driveCmd(driveCmd),
    .gainReduce(gainReduce), .timingFields(timingFields),
    .modeFields(modeFields), .sampleCycles(sampleCycles));
  assign timingBits = {timingFields.inputDirectionSelect,
    timingFields.brakeGainReduce, timingFields.sampleTimeCode,
    timingFields.blankingCode, timingFields.currentDecayPeriod};
  assign modeBits = {modeFields.noiseGateLevel,
    modeFields.rotatingMassLoopOpen, modeFields.supplyCorrectionOff,
    modeFields.realtimeSampleFormat, modeFields.resonantDriveStyle,
    modeFields.analogInputSelect, modeFields.resonantLoopOpen};
  initial
  begin
    forever #50 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  function automatic logic [8:0] expd(logic [7:0] i, logic fb,
    logic bi, logic op);
    if (!bi)
      return {1'b0, i[7:1], fb};
    if (op)
      return {i ^ 8'h80, i < 8'h80};
    return {(i <= 8'h80) ? 8'h00 : i ^ 8'h80, fb};
  endfunction : expd
  task automatic rd(logic [7:0] a, logic [7:0] e);
    q.push_back('{cyc + 2, 0, {4'h0, e}});
    host_i.acc(1'b0, a, 8'h00);
  endtask : rd
  task automatic step(logic [7:0] i, logic fb, logic bi, logic op);
    q.push_back('{cyc + 1, 1, {3'h0, expd(i, fb, bi, op)}});
    inputLevel = i;
    feedbackBrake = fb;
    @(posedge clock);
    #1;
  endtask : step
  always @(posedge clock)
  begin
    #2;
    while (q.size() > 0 && q[0].due <= cyc)
    begin
      n = q.pop_front();
      case (n.kind)
        0: `CHK(regReadData, n.v[7:0])
        1: `CHK({driveCmd.level, driveCmd.brake}, n.v[8:0])
        2: `CHK(sampleCycles, n.v)
        4: `CHK(timingBits, n.v[7:0])
        5: `CHK(modeBits, n.v[7:0])
        default: `CHK(gainReduce, n.v[0])
      endcase
    end
  end
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    #(5000 * 100);
    fails++;
    end_of_test();
  end
  initial
  begin
    logic [7:0] r;
    repeat (2) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    rd(8'h1c, 8'hda);
    rd(8'h1d, 8'ha0);
    rd(8'h1e, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      r = {rnd()} & 8'hcf | 8'(k << 4);
      q.push_back('{cyc + 2, 4, {4'h0, r}});
      q.push_back('{cyc + 3, 0, {4'h0, r}});
      q.push_back('{cyc + 3, 2, 12'((150 + 50 * k) * 10)});
      host_i.wr_rd(8'h1c, r);
      host_i.acc(1'b1, 8'h1e, ~r);
      rd(8'h1c, r);
    end
    $display("test registers done");
    for (int c = 0; c < 4; c++)
    begin
      host_i.acc(1'b1, 8'h1c, cfg[c][17:10]);
      q.push_back('{cyc + 2, 5, {4'h0, cfg[c][9:2]}});
      q.push_back('{cyc + 3, 0, {4'h0, cfg[c][9:2]}});
      host_i.wr_rd(8'h1d, cfg[c][9:2]);
      resonantActuator = cfg[c][2];
      for (int k = 0; k < 10; k++)
      begin
        r = (k < 6) ? lv[k] : rnd();
        step(r, seed[9], cfg[c][1], cfg[c][0]);
      end
    end
    $display("test mapping done");
    for (int k = 0; k < 8; k++)
    begin
      inputLevel = k[2] ? 8'hc0 : 8'h00;
      host_i.acc(1'b1, 8'h1c, {1'b1, k[1], 6'h1a});
      brakeNearDone = k[0];
      q.push_back('{cyc + 1, 3, {11'h0, k[0] & k[1] & !k[2]}});
      @(posedge clock);
      #1;
    end
    $display("test gain done");
    sys_rst = 1'b1;
    q.push_back('{cyc + 1, 1, 12'h000});
    q.push_back('{cyc + 1, 2, 12'(200 * 10)});
    q.push_back('{cyc + 1, 3, 12'h000});
    q.push_back('{cyc + 1, 4, {4'h0, 8'hda}});
    q.push_back('{cyc + 1, 5, {4'h0, 8'ha0}});
    @(posedge clock);
    #1;
    sys_rst = 1'b0;
    rd(8'h1c, 8'hda);
    rd(8'h1d, 8'ha0);
    $display("test second reset done");
    repeat (4) @(posedge clock);
    end_of_test();
  end
endmodule : tb

// ### verilog/drive_level_mapper.sv
`timescale 1ns/10ps
module drive_level_mapper
  import haptic_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] inputLevel,
  input wire logic bidirectional,
  input wire logic openLoop,
  input wire logic feedbackBrake,
  output drive_cmd_s driveCmd
);

  drive_cmd_s next_driveCmd;
  logic signed [7:0] centred;

  always_comb
  begin
    centred = $signed(inputLevel ^ HALF_SCALE);
    next_driveCmd.level = NO_DRIVE;
    next_driveCmd.brake = feedbackBrake;
    if (!bidirectional) // R10
    begin
      next_driveCmd.level = $signed({1'b0, inputLevel[7:1]});
      next_driveCmd.brake = feedbackBrake;
    end
    else if (openLoop)
    begin
      next_driveCmd.level = centred; // R2
      next_driveCmd.brake = (inputLevel < HALF_SCALE); // R1
    end
    else
    begin
      // R3
      next_driveCmd.level = (inputLevel <= HALF_SCALE) ? NO_DRIVE : centred;
      next_driveCmd.brake = feedbackBrake; // R4
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      driveCmd <= '0;
    else
      driveCmd <= next_driveCmd;
  end

endmodule : drive_level_mapper

// ### verilog/haptic_cfg_pkg.sv
package haptic_cfg_pkg;

  // register addresses on the internal register port
  localparam logic [7:0] TIMING_CTRL_ADDR = 8'h1c;
  localparam logic [7:0] MODE_SEL_ADDR = 8'h1d;

  // reset values of the two registers
  localparam logic [7:0] TIMING_CTRL_RESET = 8'hda;
  localparam logic [7:0] MODE_SEL_RESET = 8'ha0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // field reset values
  localparam logic [1:0] SAMPLE_CODE_RESET = 2'h1;
  localparam logic [1:0] BLANKING_CODE_RESET = 2'h2;
  localparam logic [1:0] DECAY_CODE_RESET = 2'h2;
  localparam logic [1:0] NOISE_GATE_RESET = 2'h2;

  // sample time codes
  localparam logic [1:0] SAMPLE_CODE_150 = 2'h0;
  localparam logic [1:0] SAMPLE_CODE_200 = 2'h1;
  localparam logic [1:0] SAMPLE_CODE_250 = 2'h2;
  localparam logic [1:0] SAMPLE_CODE_300 = 2'h3;

  // timing
  localparam int CLOCK_HZ = 10_000_000;
  localparam int CYCLES_PER_US = CLOCK_HZ / 1_000_000;
  localparam int SAMPLE_TIME_0_US = 150;
  localparam int SAMPLE_TIME_1_US = 200;
  localparam int SAMPLE_TIME_2_US = 250;
  localparam int SAMPLE_TIME_3_US = 300;
  localparam int SAMPLE_CNT_W = 12;
  localparam logic [11:0] SAMPLE_CYCLES_0 =
    12'(SAMPLE_TIME_0_US * CYCLES_PER_US);
  localparam logic [11:0] SAMPLE_CYCLES_1 =
    12'(SAMPLE_TIME_1_US * CYCLES_PER_US);
  localparam logic [11:0] SAMPLE_CYCLES_2 =
    12'(SAMPLE_TIME_2_US * CYCLES_PER_US);
  localparam logic [11:0] SAMPLE_CYCLES_3 =
    12'(SAMPLE_TIME_3_US * CYCLES_PER_US);

  // input scale
  localparam logic [7:0] HALF_SCALE = 8'h80;
  localparam logic signed [7:0] NO_DRIVE = 8'sh00;

  typedef struct packed {
    logic inputDirectionSelect;
    logic brakeGainReduce;
    logic [1:0] sampleTimeCode;
    logic [1:0] blankingCode;
    logic [1:0] currentDecayPeriod;
  } timing_ctrl_s;

  typedef struct packed {
    logic [1:0] noiseGateLevel;
    logic rotatingMassLoopOpen;
    logic supplyCorrectionOff;
    logic realtimeSampleFormat;
    logic resonantDriveStyle;
    logic analogInputSelect;
    logic resonantLoopOpen;
  } mode_sel_s;

  typedef struct packed {
    logic signed [7:0] level;
    logic brake;
  } drive_cmd_s;

endpackage : haptic_cfg_pkg

// ### verilog/haptic_loop_input_config.sv
`timescale 1ns/10ps
// Behaviour
// R1: bidir open loop brakes below half only
// R2: bidir open loop maps input linearly
// R3: bidir closed loop zero below half
// R4: bidir closed loop brakes on feedback
// R5: stabilizer bit lowers gain near brake end
// R6: sample code selects 150..300 us
// R7: blanking field bits 3:2, reset 2
// R8: decay field bits 1:0, reset 2
// R9: mode register layout, reset 0xa0
// R10: direction bit 7 selects uni/bidirectional
// R11: fields reset to defaults, read back
module haptic_loop_input_config
  import haptic_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  input wire logic [7:0] inputLevel,
  input wire logic resonantActuator,
  input wire logic feedbackBrake,
  input wire logic brakeNearDone,
  output drive_cmd_s driveCmd,
  output logic gainReduce,
  output timing_ctrl_s timingFields,
  output mode_sel_s modeFields,
  output logic [SAMPLE_CNT_W-1:0] sampleCycles
);

  timing_ctrl_s timingCtrl;
  timing_ctrl_s next_timingCtrl;
  mode_sel_s modeSel;
  mode_sel_s next_modeSel;
  logic [7:0] next_regReadData;
  logic openLoop;

  // register writes
  always_comb
  begin
    next_timingCtrl = timingCtrl;
    next_modeSel = modeSel;
    if (regWrite && regAddr == TIMING_CTRL_ADDR)
      next_timingCtrl = timing_ctrl_s'(regWriteData); // R7 R8 R11
    if (regWrite && regAddr == MODE_SEL_ADDR)
      next_modeSel = mode_sel_s'(regWriteData); // R9 R11
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      timingCtrl <= timing_ctrl_s'(TIMING_CTRL_RESET); // R11
      modeSel <= mode_sel_s'(MODE_SEL_RESET); // R9
    end
    else
    begin
      timingCtrl <= next_timingCtrl;
      modeSel <= next_modeSel;
    end
  end

  // register reads
  always_comb
  begin
    next_regReadData = regReadData;
    if (regRead)
    begin
      case (regAddr)
        TIMING_CTRL_ADDR: next_regReadData = timingCtrl; // R11
        MODE_SEL_ADDR: next_regReadData = modeSel; // R11
        default: next_regReadData = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      regReadData <= UNMAPPED_READ;
    else
      regReadData <= next_regReadData;
  end

  // loop style follows the fitted actuator
  assign openLoop = resonantActuator ? modeSel.resonantLoopOpen
                                     : modeSel.rotatingMassLoopOpen;

  drive_level_mapper mapper
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .inputLevel(inputLevel),
    .bidirectional(timingCtrl.inputDirectionSelect), // R10
    .openLoop(openLoop),
    .feedbackBrake(feedbackBrake),
    .driveCmd(driveCmd)
  );

  sample_time_select sampler
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .sampleTimeCode(timingCtrl.sampleTimeCode),
    .sampleCycles(sampleCycles)
  );

  // gain reduction while braking nears its end
  assign gainReduce = timingCtrl.brakeGainReduce && driveCmd.brake &&
                      brakeNearDone; // R5

  assign timingFields = timingCtrl; // R7 R8
  assign modeFields = modeSel;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_timing_reset: assert property ( // R11
    disable iff (1'b0) sys_rst |=> timingCtrl == TIMING_CTRL_RESET)
    else $error("timing register not at reset value");

  a_mode_reset: assert property ( // R9
    disable iff (1'b0) sys_rst |=> modeSel == MODE_SEL_RESET)
    else $error("mode register not at reset value");

  a_blank_decay_reset: assert property ( // R7
    disable iff (1'b0) sys_rst |=>
      timingCtrl.blankingCode == BLANKING_CODE_RESET &&
      timingCtrl.currentDecayPeriod == DECAY_CODE_RESET)
    else $error("blanking or decay field wrong after reset");

  a_timing_readback: assert property ( // R11
    regWrite && regAddr == TIMING_CTRL_ADDR ##1
      regRead && !regWrite && regAddr == TIMING_CTRL_ADDR |=>
      regReadData == $past(regWriteData, 2))
    else $error("timing register read does not match write");

  a_decay_field: assert property ( // R8
    regWrite && regAddr == TIMING_CTRL_ADDR |=>
      timingCtrl.currentDecayPeriod == $past(regWriteData[1:0]))
    else $error("decay field not taken from bits 1:0");

  a_open_brake: assert property ( // R1
    timingCtrl.inputDirectionSelect && openLoop |=>
      driveCmd.brake == ($past(inputLevel) < HALF_SCALE))
    else $error("open loop brake does not follow half scale");

  a_open_map: assert property ( // R2
    timingCtrl.inputDirectionSelect && openLoop |=>
      driveCmd.level == $signed($past(inputLevel) ^ HALF_SCALE))
    else $error("open loop drive level not linear");

  a_closed_zero: assert property ( // R3
    timingCtrl.inputDirectionSelect && !openLoop &&
      inputLevel <= HALF_SCALE |=> driveCmd.level == NO_DRIVE)
    else $error("closed loop drives below half scale");

  a_closed_brake: assert property ( // R4
    timingCtrl.inputDirectionSelect && !openLoop |=>
      driveCmd.brake == $past(feedbackBrake))
    else $error("closed loop brake not from feedback");

  a_gain_gate: assert property ( // R5
    gainReduce |-> timingCtrl.brakeGainReduce && driveCmd.brake)
    else $error("gain reduced without stabilizer or brake");

  a_sample_count: assert property ( // R6
    $past(timingCtrl.sampleTimeCode) == SAMPLE_CODE_300 && !$past(sys_rst)
      |-> sampleCycles == SAMPLE_CYCLES_3)
    else $error("sample count wrong for longest code");

  a_uni_map: assert property ( // R10
    !timingCtrl.inputDirectionSelect |=>
      driveCmd.level == $signed({1'b0, $past(inputLevel[7:1])}))
    else $error("unidirectional mapping wrong");

  a_uni_brake: assert property ( // R10
    !timingCtrl.inputDirectionSelect |=>
      driveCmd.brake == $past(feedbackBrake))
    else $error("unidirectional brake not from feedback");

  a_dir_reset: assert property ( // R10
    disable iff (1'h0) sys_rst |=> timingCtrl.inputDirectionSelect)
    else $error("direction bit not bidirectional after reset");

  a_stab_reset: assert property ( // R5
    disable iff (1'h0) sys_rst |=> timingCtrl.brakeGainReduce)
    else $error("stabilizer bit clear after reset");

  a_sample_reset: assert property ( // R6
    disable iff (1'h0) sys_rst |=>
      timingCtrl.sampleTimeCode == SAMPLE_CODE_RESET)
    else $error("sample code wrong after reset");

  a_gate_reset: assert property ( // R9
    disable iff (1'h0) sys_rst |=>
      modeSel.noiseGateLevel == NOISE_GATE_RESET)
    else $error("noise gate level wrong after reset");

  a_read_reset: assert property ( // R11
    disable iff (1'h0) sys_rst |=> regReadData == UNMAPPED_READ)
    else $error("read data not cleared by reset");

  a_dir_field: assert property ( // R10
    regWrite && regAddr == TIMING_CTRL_ADDR |=>
      timingCtrl.inputDirectionSelect == $past(regWriteData[7]))
    else $error("direction bit not taken from bit 7");

  a_stab_field: assert property ( // R5
    regWrite && regAddr == TIMING_CTRL_ADDR |=>
      timingCtrl.brakeGainReduce == $past(regWriteData[6]))
    else $error("stabilizer bit not taken from bit 6");

  a_sample_field: assert property ( // R6
    regWrite && regAddr == TIMING_CTRL_ADDR |=>
      timingCtrl.sampleTimeCode == $past(regWriteData[5:4]))
    else $error("sample code not taken from bits 5:4");

  a_blank_field: assert property ( // R7
    regWrite && regAddr == TIMING_CTRL_ADDR |=>
      timingCtrl.blankingCode == $past(regWriteData[3:2]))
    else $error("blanking field not taken from bits 3:2");

  a_mode_fields: assert property ( // R9
    regWrite && regAddr == MODE_SEL_ADDR |=>
      {modeSel.noiseGateLevel, modeSel.rotatingMassLoopOpen,
       modeSel.supplyCorrectionOff, modeSel.realtimeSampleFormat,
       modeSel.resonantDriveStyle, modeSel.analogInputSelect,
       modeSel.resonantLoopOpen} == $past(regWriteData))
    else $error("mode register fields out of place");

  a_gate_field: assert property ( // R9
    regWrite && regAddr == MODE_SEL_ADDR |=>
      modeSel.noiseGateLevel == $past(regWriteData[7:6]))
    else $error("noise gate not taken from bits 7:6");

  a_mass_open_field: assert property ( // R9
    regWrite && regAddr == MODE_SEL_ADDR |=>
      modeSel.rotatingMassLoopOpen == $past(regWriteData[5]))
    else $error("rotating mass loop bit not taken from bit 5");

  a_mode_readback: assert property ( // R11
    regWrite && regAddr == MODE_SEL_ADDR ##1
      regRead && !regWrite && regAddr == MODE_SEL_ADDR |=>
      regReadData == $past(regWriteData, 2))
    else $error("mode register read does not match write");

  a_timing_read: assert property ( // R11
    regRead && regAddr == TIMING_CTRL_ADDR |=>
      regReadData == $past(timingCtrl))
    else $error("timing register read not current");

  a_mode_read: assert property ( // R9
    regRead && regAddr == MODE_SEL_ADDR |=>
      regReadData == $past(modeSel))
    else $error("mode register read not current");

  a_read_unmapped: assert property ( // R11
    regRead && regAddr != TIMING_CTRL_ADDR && regAddr != MODE_SEL_ADDR |=>
      regReadData == UNMAPPED_READ)
    else $error("unmapped read not zero");

  a_read_hold: assert property ( // R11
    !regRead |=> $stable(regReadData))
    else $error("read data changed without a read");

  a_other_write: assert property ( // R11
    regWrite && regAddr != TIMING_CTRL_ADDR && regAddr != MODE_SEL_ADDR |=>
      $stable(timingCtrl) && $stable(modeSel))
    else $error("write to other address changed a register");

  a_sample_150: assert property ( // R6
    $past(timingCtrl.sampleTimeCode) == SAMPLE_CODE_150 && !$past(sys_rst)
      |-> sampleCycles == SAMPLE_CYCLES_0)
    else $error("sample count wrong for shortest code");

  a_sample_200: assert property ( // R6
    $past(timingCtrl.sampleTimeCode) == SAMPLE_CODE_200 && !$past(sys_rst)
      |-> sampleCycles == SAMPLE_CYCLES_1)
    else $error("sample count wrong for second code");

  a_sample_250: assert property ( // R6
    $past(timingCtrl.sampleTimeCode) == SAMPLE_CODE_250 && !$past(sys_rst)
      |-> sampleCycles == SAMPLE_CYCLES_2)
    else $error("sample count wrong for third code");

  a_open_nobrake: assert property ( // R1
    timingCtrl.inputDirectionSelect && openLoop &&
      inputLevel >= HALF_SCALE |=> !driveCmd.brake)
    else $error("open loop brakes at or above half scale");

  a_closed_drive: assert property ( // R3
    timingCtrl.inputDirectionSelect && !openLoop &&
      inputLevel > HALF_SCALE |=>
      driveCmd.level == $signed($past(inputLevel) ^ HALF_SCALE))
    else $error("closed loop drive above half scale wrong");

  a_gain_apply: assert property ( // R5
    timingCtrl.brakeGainReduce && driveCmd.brake && brakeNearDone
      |-> gainReduce)
    else $error("gain not reduced near brake end");

  c_timing_write: cover property (
    regWrite && regAddr == TIMING_CTRL_ADDR);
  c_open_brake: cover property (
    timingCtrl.inputDirectionSelect && openLoop ##1 driveCmd.brake);
  c_closed_drive: cover property (
    !openLoop ##1 driveCmd.level != NO_DRIVE);
  c_gain_reduce: cover property (gainReduce);
  c_mode_readback: cover property (
    regWrite && regAddr == MODE_SEL_ADDR ##1 regRead);

endmodule : haptic_loop_input_config

// ### verilog/sample_time_select.sv
`timescale 1ns/10ps
module sample_time_select
  import haptic_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [1:0] sampleTimeCode,
  output logic [SAMPLE_CNT_W-1:0] sampleCycles
);

  logic [SAMPLE_CNT_W-1:0] next_sampleCycles;

  always_comb
  begin
    case (sampleTimeCode) // R6
      SAMPLE_CODE_150: next_sampleCycles = SAMPLE_CYCLES_0;
      SAMPLE_CODE_200: next_sampleCycles = SAMPLE_CYCLES_1;
      SAMPLE_CODE_250: next_sampleCycles = SAMPLE_CYCLES_2;
      SAMPLE_CODE_300: next_sampleCycles = SAMPLE_CYCLES_3;
      default: next_sampleCycles = SAMPLE_CYCLES_1;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      sampleCycles <= SAMPLE_CYCLES_1;
    else
      sampleCycles <= next_sampleCycles;
  end

endmodule : sample_time_select
